// >>> include/tcrb_pkg.sv
// Purpose: Constants shared by the tuner configuration register bank.
// Assumes: 16-bit registers placed one per 32-bit Avalon word.
// Notes: Byte address of a register is four times its index.

package tcrb_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam logic [7:0] TCRB_IDX_SEEK_BAND_VOL = 8'h05;
  localparam logic [7:0] TCRB_IDX_SMUTE_QUAL = 8'h06;
  localparam logic [7:0] TCRB_IDX_OSC_BIAS_TEST = 8'h07;
  localparam logic [7:0] TCRB_IDX_STATUS = 8'h10;
  localparam logic [7:0] TCRB_ADDR_SEEK_BAND_VOL = {TCRB_IDX_SEEK_BAND_VOL[5:0], 2'h0};
  localparam logic [7:0] TCRB_ADDR_SMUTE_QUAL = {TCRB_IDX_SMUTE_QUAL[5:0], 2'h0};
  localparam logic [7:0] TCRB_ADDR_OSC_BIAS_TEST = {TCRB_IDX_OSC_BIAS_TEST[5:0], 2'h0};
  localparam logic [7:0] TCRB_ADDR_STATUS = {TCRB_IDX_STATUS[5:0], 2'h0};

  // ****************************************************************
  // Reset values and writable masks
  // ****************************************************************
  localparam logic [15:0] TCRB_RST_SEEK_BAND_VOL = 16'h0000;
  localparam logic [15:0] TCRB_RST_SMUTE_QUAL = 16'h0000;
  localparam logic [15:0] TCRB_RST_OSC_BIAS_TEST = 16'h0100;
  localparam logic [15:0] TCRB_MASK_SEEK_BAND_VOL = 16'hFFFF;
  localparam logic [15:0] TCRB_MASK_SMUTE_QUAL = 16'hF1FF;
  localparam logic [15:0] TCRB_MASK_OSC_BIAS_TEST = 16'hFFFF;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int TCRB_SEEK_LEVEL_LSB = 8;
  localparam int TCRB_BAND_LSB = 6;
  localparam int TCRB_SPACE_LSB = 4;
  localparam int TCRB_VOLUME_LSB = 0;
  localparam int TCRB_SMUTE_RATE_LSB = 14;
  localparam int TCRB_SMUTE_DEPTH_LSB = 12;
  localparam int TCRB_EXTRA_ATT_BIT = 8;
  localparam int TCRB_NOISE_RATIO_LSB = 4;
  localparam int TCRB_IMPULSE_LSB = 0;
  localparam int TCRB_XOSC_BIT = 15;
  localparam int TCRB_AUDIO_BIAS_BIT = 14;
  localparam int TCRB_ST_BAND_INVALID = 0;
  localparam int TCRB_ST_SPACE_INVALID = 1;
  localparam int TCRB_ST_BIAS_ACTIVE = 2;
  localparam int TCRB_ST_IO_PRESENT = 3;
  localparam int TCRB_ST_POWERED_UP = 4;

  // ****************************************************************
  // Band, spacing and level constants
  // ****************************************************************
  localparam logic [1:0] TCRB_BAND_WIDE_EU = 2'h0;
  localparam logic [1:0] TCRB_BAND_WIDE_JP = 2'h1;
  localparam logic [1:0] TCRB_BAND_NARROW_JP = 2'h2;
  localparam logic [1:0] TCRB_SPACE_200 = 2'h0;
  localparam logic [1:0] TCRB_SPACE_100 = 2'h1;
  localparam logic [1:0] TCRB_SPACE_50 = 2'h2;
  localparam logic [18:0] TCRB_BASE_875_KHZ = 19'h155CC;
  localparam logic [18:0] TCRB_BASE_760_KHZ = 19'h128E0;
  localparam logic [18:0] TCRB_TOP_1080_KHZ = 19'h1A5E0;
  localparam logic [18:0] TCRB_TOP_900_KHZ = 19'h15F90;
  localparam logic [7:0] TCRB_STEP_200_KHZ = 8'hC8;
  localparam logic [7:0] TCRB_STEP_100_KHZ = 8'h64;
  localparam logic [7:0] TCRB_STEP_50_KHZ = 8'h32;
  localparam logic [5:0] TCRB_VOL_BASE_DB = 6'h1E;
  localparam logic [5:0] TCRB_VOL_EXTRA_DB = 6'h1E;
  localparam logic [4:0] TCRB_SMUTE_DEPTH_MAX_DB = 5'h10;
  localparam logic [4:0] TCRB_IMPULSE_SPAN = 5'h10;

endpackage : tcrb_pkg

// >>> rtl/tcrb_config_bank.sv
// Purpose: Tuner configuration register bank with decoded controls and seek qualification.
// Assumes: Avalon-MM slave with waitrequest; one 100 MHz clock CLK; synchronous RESET.
// Notes: Each access completes in two cycles; unmapped reads return zero.

`timescale 1ns/1ns

module tcrb_config_bank (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDRESS,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic [31:0] WRITEDATA,
  input wire logic [3:0] BYTEENABLE,
  output logic [31:0] READDATA,
  output logic WAITREQUEST,
  input wire logic POWERED_UP,
  input wire logic IO_SUPPLY_PRESENT,
  input wire logic [9:0] TUNE_CHANNEL_INDEX,
  input wire logic CANDIDATE_VALID,
  input wire logic [7:0] CANDIDATE_LEVEL,
  input wire logic [3:0] CANDIDATE_NOISE_RATIO,
  input wire logic [4:0] CANDIDATE_IMPULSES,
  output logic SEEK_ACCEPT,
  output logic SEEK_REJECT,
  output logic [7:0] SEEK_LEVEL_THRESHOLD,
  output logic [3:0] SEEK_NOISE_RATIO_THRESHOLD,
  output logic [3:0] SEEK_IMPULSE_LIMIT,
  output logic [1:0] BAND_SELECT,
  output logic BAND_INVALID,
  output logic [18:0] BAND_LOW_KHZ,
  output logic [18:0] BAND_HIGH_KHZ,
  output logic [7:0] CHANNEL_STEP_KHZ,
  output logic SPACING_INVALID,
  output logic [18:0] TUNED_FREQ_KHZ,
  output logic VOLUME_MUTE,
  output logic [5:0] VOLUME_ATTEN_DB,
  output logic EXTRA_ATTENUATION_SELECT,
  output logic [1:0] SOFTMUTE_RATE,
  output logic [4:0] SOFTMUTE_DEPTH_DB,
  output logic CRYSTAL_OSC_ENABLE,
  output logic LEFT_AUDIO_OUTPUT_BIAS,
  output logic RIGHT_AUDIO_OUTPUT_BIAS
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [15:0] seek_band_volume_config;
    logic [15:0] softmute_seek_quality_config;
    logic [15:0] oscillator_audio_bias_test;
    logic wait_req;
    logic [31:0] readdata;
    logic io_sync1;
    logic io_sync2;
    logic io_sync3;
    logic io_present;
    logic seek_accept;
    logic seek_reject;
    logic [7:0] level_th;
    logic [3:0] noise_th;
    logic [3:0] impulse_lim;
    logic [1:0] band;
    logic band_invalid;
    logic [18:0] band_low;
    logic [18:0] band_high;
    logic [7:0] step;
    logic space_invalid;
    logic [18:0] freq;
    logic mute;
    logic [5:0] atten;
    logic extra_att;
    logic [1:0] smute_rate;
    logic [4:0] smute_depth;
    logic xosc;
    logic bias_active;
  } tcrb_state_s;

  tcrb_state_s state_ff;
  tcrb_state_s nxt_state;

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [15:0] tcrb_merge(input logic [15:0] old, input logic [31:0] data,
                                             input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}};
    tcrb_merge = (old & ~lanes) | (data[15:0] & lanes & mask);
  endfunction : tcrb_merge

  function automatic logic [7:0] tcrb_step(input logic [1:0] code);
    case (code)
      tcrb_pkg::TCRB_SPACE_200: tcrb_step = tcrb_pkg::TCRB_STEP_200_KHZ;
      tcrb_pkg::TCRB_SPACE_100: tcrb_step = tcrb_pkg::TCRB_STEP_100_KHZ;
      tcrb_pkg::TCRB_SPACE_50: tcrb_step = tcrb_pkg::TCRB_STEP_50_KHZ;
      default: tcrb_step = tcrb_pkg::TCRB_STEP_200_KHZ;
    endcase
  endfunction : tcrb_step

  function automatic logic [18:0] tcrb_base(input logic [1:0] band);
    if (band == tcrb_pkg::TCRB_BAND_WIDE_EU) begin
      tcrb_base = tcrb_pkg::TCRB_BASE_875_KHZ;
    end else begin
      tcrb_base = tcrb_pkg::TCRB_BASE_760_KHZ;
    end
  endfunction : tcrb_base

  function automatic logic [5:0] tcrb_level_db(input logic [3:0] code);
    logic [5:0] doubled;
    doubled = {1'b0, code, 1'b0};
    tcrb_level_db = tcrb_pkg::TCRB_VOL_BASE_DB - doubled;
  endfunction : tcrb_level_db

  // ****************************************************************
  // Field views
  // ****************************************************************
  logic [7:0] f_level;
  logic [1:0] f_band;
  logic [1:0] f_space;
  logic [3:0] f_volume;
  logic [1:0] f_rate;
  logic [1:0] f_depth;
  logic f_extra;
  logic [3:0] f_noise;
  logic [3:0] f_impulse;
  logic [17:0] step_product;
  logic [15:0] status_word;
  logic level_ok;
  logic noise_ok;
  logic impulse_ok;

  assign f_level = state_ff.seek_band_volume_config[tcrb_pkg::TCRB_SEEK_LEVEL_LSB +: 8];
  assign f_band = state_ff.seek_band_volume_config[tcrb_pkg::TCRB_BAND_LSB +: 2];
  assign f_space = state_ff.seek_band_volume_config[tcrb_pkg::TCRB_SPACE_LSB +: 2];
  assign f_volume = state_ff.seek_band_volume_config[tcrb_pkg::TCRB_VOLUME_LSB +: 4];
  assign f_rate = state_ff.softmute_seek_quality_config[tcrb_pkg::TCRB_SMUTE_RATE_LSB +: 2];
  assign f_depth = state_ff.softmute_seek_quality_config[tcrb_pkg::TCRB_SMUTE_DEPTH_LSB +: 2];
  assign f_extra = state_ff.softmute_seek_quality_config[tcrb_pkg::TCRB_EXTRA_ATT_BIT];
  assign f_noise = state_ff.softmute_seek_quality_config[tcrb_pkg::TCRB_NOISE_RATIO_LSB +: 4];
  assign f_impulse = state_ff.softmute_seek_quality_config[tcrb_pkg::TCRB_IMPULSE_LSB +: 4];

  // ****************************************************************
  // Tuned frequency product
  // ****************************************************************
  assign step_product = tcrb_step(f_space) * TUNE_CHANNEL_INDEX;

  // ****************************************************************
  // Seek qualification
  // ****************************************************************
  // Seek qualification terms.
  assign level_ok = CANDIDATE_LEVEL >= f_level;
  assign noise_ok = (f_noise == 4'h0) || ({1'b0, CANDIDATE_NOISE_RATIO} >= {1'b0, f_noise});
  assign impulse_ok = (f_impulse == 4'h0) ||
                      (CANDIDATE_IMPULSES <= (tcrb_pkg::TCRB_IMPULSE_SPAN - {1'b0, f_impulse}));

  // ****************************************************************
  // Status word
  // ****************************************************************
  always_comb begin
    status_word = 16'h0000;
    status_word[tcrb_pkg::TCRB_ST_BAND_INVALID] = state_ff.band_invalid;
    status_word[tcrb_pkg::TCRB_ST_SPACE_INVALID] = state_ff.space_invalid;
    status_word[tcrb_pkg::TCRB_ST_BIAS_ACTIVE] = state_ff.bias_active;
    status_word[tcrb_pkg::TCRB_ST_IO_PRESENT] = state_ff.io_present;
    status_word[tcrb_pkg::TCRB_ST_POWERED_UP] = POWERED_UP;
  end

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_state = state_ff;

    // Supply detect pin passes three flops and updates once the last two agree.
    nxt_state.io_sync1 = IO_SUPPLY_PRESENT;
    nxt_state.io_sync2 = state_ff.io_sync1;
    nxt_state.io_sync3 = state_ff.io_sync2;
    if (state_ff.io_sync2 == state_ff.io_sync3) begin
      nxt_state.io_present = state_ff.io_sync3;
    end

    // Bus slave: take request with waitrequest high, answer on the following cycle.
    if (!state_ff.wait_req) begin
      nxt_state.wait_req = 1'b1;
      if (WRITE) begin
        case (ADDRESS)
          tcrb_pkg::TCRB_ADDR_SEEK_BAND_VOL: begin
            nxt_state.seek_band_volume_config = tcrb_merge(state_ff.seek_band_volume_config, WRITEDATA,
                                                           BYTEENABLE, tcrb_pkg::TCRB_MASK_SEEK_BAND_VOL);
          end
          tcrb_pkg::TCRB_ADDR_SMUTE_QUAL: begin
            nxt_state.softmute_seek_quality_config = tcrb_merge(state_ff.softmute_seek_quality_config,
                                                                WRITEDATA, BYTEENABLE,
                                                                tcrb_pkg::TCRB_MASK_SMUTE_QUAL);
          end
          tcrb_pkg::TCRB_ADDR_OSC_BIAS_TEST: begin
            nxt_state.oscillator_audio_bias_test = tcrb_merge(state_ff.oscillator_audio_bias_test, WRITEDATA,
                                                              BYTEENABLE, tcrb_pkg::TCRB_MASK_OSC_BIAS_TEST);
          end
          default: begin
            nxt_state.readdata = 32'h00000000;
          end
        endcase
      end
    end else if (READ || WRITE) begin
      nxt_state.wait_req = 1'b0;
      case (ADDRESS)
        tcrb_pkg::TCRB_ADDR_SEEK_BAND_VOL: nxt_state.readdata = {16'h0000, state_ff.seek_band_volume_config};
        tcrb_pkg::TCRB_ADDR_SMUTE_QUAL: nxt_state.readdata = {16'h0000, state_ff.softmute_seek_quality_config};
        tcrb_pkg::TCRB_ADDR_OSC_BIAS_TEST: nxt_state.readdata = {16'h0000, state_ff.oscillator_audio_bias_test};
        tcrb_pkg::TCRB_ADDR_STATUS: nxt_state.readdata = {16'h0000, status_word};
        default: nxt_state.readdata = 32'h00000000;
      endcase
    end

    // Seek candidate verdict, one pulse per candidate.
    nxt_state.seek_accept = CANDIDATE_VALID && level_ok && noise_ok && impulse_ok;
    nxt_state.seek_reject = CANDIDATE_VALID && !(level_ok && noise_ok && impulse_ok);
    nxt_state.level_th = f_level;
    nxt_state.noise_th = f_noise;
    nxt_state.impulse_lim = f_impulse;

    // Band decode.
    nxt_state.band = f_band;
    nxt_state.band_invalid = 1'b0;
    case (f_band)
      tcrb_pkg::TCRB_BAND_WIDE_EU: begin
        nxt_state.band_low = tcrb_pkg::TCRB_BASE_875_KHZ;
        nxt_state.band_high = tcrb_pkg::TCRB_TOP_1080_KHZ;
      end
      tcrb_pkg::TCRB_BAND_WIDE_JP: begin
        nxt_state.band_low = tcrb_pkg::TCRB_BASE_760_KHZ;
        nxt_state.band_high = tcrb_pkg::TCRB_TOP_1080_KHZ;
      end
      tcrb_pkg::TCRB_BAND_NARROW_JP: begin
        nxt_state.band_low = tcrb_pkg::TCRB_BASE_760_KHZ;
        nxt_state.band_high = tcrb_pkg::TCRB_TOP_900_KHZ;
      end
      default: begin
        nxt_state.band_low = 19'h00000;
        nxt_state.band_high = 19'h00000;
        nxt_state.band_invalid = 1'b1;
      end
    endcase

    // Spacing decode and tuned frequency.
    nxt_state.step = tcrb_step(f_space);
    nxt_state.space_invalid = (f_space == 2'h3);
    nxt_state.freq = {1'b0, step_product} + tcrb_base(f_band);

    // Output level: 2 dB steps from -28 dBFS, extended range adds 30 dB.
    nxt_state.mute = (f_volume == 4'h0);
    nxt_state.extra_att = f_extra;
    if (f_volume == 4'h0) begin
      nxt_state.atten = 6'h00;
    end else if (f_extra) begin
      nxt_state.atten = tcrb_level_db(f_volume) + tcrb_pkg::TCRB_VOL_EXTRA_DB;
    end else begin
      nxt_state.atten = tcrb_level_db(f_volume);
    end

    // Softmute controls.
    nxt_state.smute_rate = f_rate;
    nxt_state.smute_depth = tcrb_pkg::TCRB_SMUTE_DEPTH_MAX_DB - {2'h0, f_depth, 1'b0};

    // Oscillator and audio float bias.
    nxt_state.xosc = state_ff.oscillator_audio_bias_test[tcrb_pkg::TCRB_XOSC_BIT];
    nxt_state.bias_active = state_ff.oscillator_audio_bias_test[tcrb_pkg::TCRB_AUDIO_BIAS_BIT] &&
                            !POWERED_UP && state_ff.io_present;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_ff <= '0;
      state_ff.wait_req <= 1'b1;
      state_ff.seek_band_volume_config <= tcrb_pkg::TCRB_RST_SEEK_BAND_VOL;
      state_ff.softmute_seek_quality_config <= tcrb_pkg::TCRB_RST_SMUTE_QUAL;
      state_ff.oscillator_audio_bias_test <= tcrb_pkg::TCRB_RST_OSC_BIAS_TEST;
      state_ff.band_low <= tcrb_pkg::TCRB_BASE_875_KHZ;
      state_ff.band_high <= tcrb_pkg::TCRB_TOP_1080_KHZ;
      state_ff.step <= tcrb_pkg::TCRB_STEP_200_KHZ;
      state_ff.freq <= tcrb_pkg::TCRB_BASE_875_KHZ;
      state_ff.mute <= 1'b1;
      state_ff.smute_depth <= tcrb_pkg::TCRB_SMUTE_DEPTH_MAX_DB;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign READDATA = state_ff.readdata;
  assign WAITREQUEST = state_ff.wait_req;
  assign SEEK_ACCEPT = state_ff.seek_accept;
  assign SEEK_REJECT = state_ff.seek_reject;
  assign SEEK_LEVEL_THRESHOLD = state_ff.level_th;
  assign SEEK_NOISE_RATIO_THRESHOLD = state_ff.noise_th;
  assign SEEK_IMPULSE_LIMIT = state_ff.impulse_lim;
  assign BAND_SELECT = state_ff.band;
  assign BAND_INVALID = state_ff.band_invalid;
  assign BAND_LOW_KHZ = state_ff.band_low;
  assign BAND_HIGH_KHZ = state_ff.band_high;
  assign CHANNEL_STEP_KHZ = state_ff.step;
  assign SPACING_INVALID = state_ff.space_invalid;
  assign TUNED_FREQ_KHZ = state_ff.freq;
  assign VOLUME_MUTE = state_ff.mute;
  assign VOLUME_ATTEN_DB = state_ff.atten;
  assign EXTRA_ATTENUATION_SELECT = state_ff.extra_att;
  assign SOFTMUTE_RATE = state_ff.smute_rate;
  assign SOFTMUTE_DEPTH_DB = state_ff.smute_depth;
  assign CRYSTAL_OSC_ENABLE = state_ff.xosc;
  assign LEFT_AUDIO_OUTPUT_BIAS = state_ff.bias_active;
  assign RIGHT_AUDIO_OUTPUT_BIAS = state_ff.bias_active;

endmodule : tcrb_config_bank

// >>> bench/tcrb_properties.sv
// Purpose: Concurrent checks on the ports of the register bank.
// Assumes: One clock CLK and a synchronous RESET.
// Notes: Attached to every register bank instance by bind.
`timescale 1ns/1ns
module tcrb_properties (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic READ,
  input wire logic WRITE,
  input wire logic WAITREQUEST,
  input wire logic POWERED_UP,
  input wire logic CANDIDATE_VALID,
  input wire logic [7:0] CANDIDATE_LEVEL,
  input wire logic [3:0] CANDIDATE_NOISE_RATIO,
  input wire logic [4:0] CANDIDATE_IMPULSES,
  input wire logic SEEK_ACCEPT,
  input wire logic SEEK_REJECT,
  input wire logic [7:0] SEEK_LEVEL_THRESHOLD,
  input wire logic [3:0] SEEK_NOISE_RATIO_THRESHOLD,
  input wire logic [3:0] SEEK_IMPULSE_LIMIT,
  input wire logic [1:0] BAND_SELECT,
  input wire logic BAND_INVALID,
  input wire logic [18:0] BAND_LOW_KHZ,
  input wire logic [18:0] BAND_HIGH_KHZ,
  input wire logic LEFT_AUDIO_OUTPUT_BIAS,
  input wire logic RIGHT_AUDIO_OUTPUT_BIAS
);
  // ****************************************************************
  // Port relations
  // ****************************************************************
  logic pass_ok;
  assign pass_ok = (CANDIDATE_LEVEL >= SEEK_LEVEL_THRESHOLD)
    && (SEEK_NOISE_RATIO_THRESHOLD == 4'h0 || CANDIDATE_NOISE_RATIO >= SEEK_NOISE_RATIO_THRESHOLD)
    && (SEEK_IMPULSE_LIMIT == 4'h0 || CANDIDATE_IMPULSES <= 5'h10 - {1'b0, SEEK_IMPULSE_LIMIT});
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  property p_wait_one; (READ || WRITE) && WAITREQUEST |=> !WAITREQUEST ##1 WAITREQUEST; endproperty
  a_wait_one: assert property (p_wait_one) else $error("access not answered in one cycle");
  property p_wait_rest; !READ && !WRITE && WAITREQUEST |=> WAITREQUEST; endproperty
  a_wait_rest: assert property (p_wait_rest) else $error("wait released without request");
  property p_seek_one; CANDIDATE_VALID |=> SEEK_ACCEPT != SEEK_REJECT; endproperty
  a_seek_one: assert property (p_seek_one) else $error("seek verdict not exactly one pulse");
  property p_pass; CANDIDATE_VALID && $past(WAITREQUEST) |=> SEEK_ACCEPT == $past(pass_ok); endproperty
  a_pass: assert property (p_pass) else $error("seek verdict wrong");
  property p_band_eu; BAND_SELECT == 2'h0 |-> BAND_LOW_KHZ == 19'h155CC && BAND_HIGH_KHZ == 19'h1A5E0; endproperty
  a_band_eu: assert property (p_band_eu) else $error("band 0 limits wrong");
  property p_band_jp; BAND_SELECT == 2'h2 |-> BAND_LOW_KHZ == 19'h128E0 && BAND_HIGH_KHZ == 19'h15F90; endproperty
  a_band_jp: assert property (p_band_jp) else $error("band 2 limits wrong");
  property p_band_wj; BAND_SELECT == 2'h1 |-> BAND_LOW_KHZ == 19'h128E0 && BAND_HIGH_KHZ == 19'h1A5E0; endproperty
  a_band_wj: assert property (p_band_wj) else $error("band 1 limits wrong");
  property p_band_bad; BAND_SELECT == 2'h3 |-> BAND_INVALID && BAND_HIGH_KHZ == 19'h00000; endproperty
  a_band_bad: assert property (p_band_bad) else $error("reserved band not flagged");
  property p_bias; LEFT_AUDIO_OUTPUT_BIAS || RIGHT_AUDIO_OUTPUT_BIAS
    |-> LEFT_AUDIO_OUTPUT_BIAS == RIGHT_AUDIO_OUTPUT_BIAS && !$past(POWERED_UP); endproperty
  a_bias: assert property (p_bias) else $error("bias active while powered up");
  c_accept: cover property (SEEK_ACCEPT);
  c_reject: cover property (SEEK_REJECT);
  c_bias: cover property (LEFT_AUDIO_OUTPUT_BIAS);
endmodule : tcrb_properties

bind tcrb_config_bank tcrb_properties u_props (.CLK(CLK), .RESET(RESET), .READ(READ), .WRITE(WRITE),
  .WAITREQUEST(WAITREQUEST), .POWERED_UP(POWERED_UP), .CANDIDATE_VALID(CANDIDATE_VALID),
  .CANDIDATE_LEVEL(CANDIDATE_LEVEL), .CANDIDATE_NOISE_RATIO(CANDIDATE_NOISE_RATIO),
  .CANDIDATE_IMPULSES(CANDIDATE_IMPULSES), .SEEK_ACCEPT(SEEK_ACCEPT), .SEEK_REJECT(SEEK_REJECT),
  .SEEK_LEVEL_THRESHOLD(SEEK_LEVEL_THRESHOLD), .SEEK_NOISE_RATIO_THRESHOLD(SEEK_NOISE_RATIO_THRESHOLD),
  .SEEK_IMPULSE_LIMIT(SEEK_IMPULSE_LIMIT), .BAND_SELECT(BAND_SELECT), .BAND_INVALID(BAND_INVALID),
  .BAND_LOW_KHZ(BAND_LOW_KHZ), .BAND_HIGH_KHZ(BAND_HIGH_KHZ),
  .LEFT_AUDIO_OUTPUT_BIAS(LEFT_AUDIO_OUTPUT_BIAS), .RIGHT_AUDIO_OUTPUT_BIAS(RIGHT_AUDIO_OUTPUT_BIAS));

// >>> bench/tcrb_host_model.sv
// Purpose: Host controller model driving the register bank as an Avalon master.
// Assumes: Slave answers by dropping waitrequest.
// Notes: Raises timed_out when an access is not answered within 40 cycles.
`timescale 1ns/1ns
module tcrb_host_model (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [7:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  output logic powered_up,
  output logic timed_out
);
  // ****************************************************************
  // Bus access and power sequencing
  // ****************************************************************
  initial {address, read, write, writedata, byteenable, powered_up, timed_out} = '0;
  task automatic xfer(input logic [7:0] a, input logic w, input logic [15:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    int n;
    @(posedge clk);
    address <= a;
    read <= !w;
    write <= w;
    writedata <= {16'h0000, d};
    byteenable <= be;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 40);
    q = readdata;
    if (waitrequest !== 1'b0) timed_out <= 1'b1;
    read <= 1'b0;
    write <= 1'b0;
    address <= ~a;
    writedata <= ~{16'h0000, d};
  endtask : xfer
  task automatic up(input logic hiz);
    logic [31:0] r;
    xfer(8'h1C, 1'b0, 16'h0000, 4'h3, r);
    xfer(8'h1C, 1'b1, {1'b1, hiz, r[13:0]}, 4'h3, r);
    @(posedge clk) powered_up <= 1'b1;
    repeat (4) @(posedge clk);
    xfer(8'h1C, 1'b1, {1'b1, hiz, 14'h3C04}, 4'h3, r);
  endtask : up
  task automatic down(input logic hiz);
    logic [31:0] r;
    @(posedge clk) powered_up <= 1'b0;
    xfer(8'h1C, 1'b1, {1'b0, hiz, 14'h0100}, 4'h3, r);
  endtask : down
endmodule : tcrb_host_model

// >>> bench/tb_top.sv
// Purpose: Self-checking bench for the tuner register bank.
// Assumes: Host model drives the bus, bench drives the seek side.
// Notes: Random values from a fixed-seed xorshift.
`timescale 1ns/1ns
module tb_top;
  // ****************************************************************
  // Stimulus and checking
  // ****************************************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic io = 1'b1;
  logic cv = 1'b0;
  logic [9:0] tune_channel_index = 10'h000;
  logic [7:0] cl = 8'h00;
  logic [3:0] cn = 4'h0;
  logic [4:0] ci = 5'h00;
  logic [7:0] addr;
  logic rd, wr_s, wt, pu, to, acc, bi, sm, ext, xo, bl, br;
  logic [31:0] wd, rdata;
  logic [3:0] be;
  logic [7:0] step;
  logic [18:0] freq;
  logic [5:0] att;
  logic [1:0] rate;
  logic [4:0] dep;
  logic [31:0] x = 32'h76C7;
  int miscompares = 0;
  int check_count = 0;
  initial forever #5 clk = ~clk;
  tcrb_host_model u_host (.clk(clk), .waitrequest(wt), .readdata(rdata), .address(addr), .read(rd),
    .write(wr_s), .writedata(wd), .byteenable(be), .powered_up(pu), .timed_out(to));
  tcrb_config_bank u_dut (.CLK(clk), .RESET(rst), .ADDRESS(addr), .READ(rd), .WRITE(wr_s), .WRITEDATA(wd),
    .BYTEENABLE(be), .READDATA(rdata), .WAITREQUEST(wt), .POWERED_UP(pu), .IO_SUPPLY_PRESENT(io),
    .TUNE_CHANNEL_INDEX(tune_channel_index), .CANDIDATE_VALID(cv), .CANDIDATE_LEVEL(cl), .CANDIDATE_NOISE_RATIO(cn),
    .CANDIDATE_IMPULSES(ci), .SEEK_ACCEPT(acc), .SEEK_REJECT(), .SEEK_LEVEL_THRESHOLD(),
    .SEEK_NOISE_RATIO_THRESHOLD(), .SEEK_IMPULSE_LIMIT(), .BAND_SELECT(), .BAND_INVALID(bi),
    .BAND_LOW_KHZ(), .BAND_HIGH_KHZ(), .CHANNEL_STEP_KHZ(step), .SPACING_INVALID(), .TUNED_FREQ_KHZ(freq),
    .VOLUME_MUTE(sm), .VOLUME_ATTEN_DB(att), .EXTRA_ATTENUATION_SELECT(ext), .SOFTMUTE_RATE(rate),
    .SOFTMUTE_DEPTH_DB(dep), .CRYSTAL_OSC_ENABLE(xo), .LEFT_AUDIO_OUTPUT_BIAS(bl), .RIGHT_AUDIO_OUTPUT_BIAS(br));
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : rnd
  function automatic logic [7:0] exp_step(input logic [1:0] s);
    return (s == 2'h1) ? 8'h64 : (s == 2'h2) ? 8'h32 : 8'hC8;
  endfunction : exp_step
  function automatic logic [5:0] exp_att(input logic [3:0] v, input logic e);
    return (v == 4'h0) ? 6'h00 : 6'h1E - {1'b0, v, 1'b0} + (e ? 6'h1E : 6'h00);
  endfunction : exp_att
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] b);
    logic [31:0] q;
    u_host.xfer(a, 1'b1, d, b, q);
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    u_host.xfer(a, 1'b0, 16'h0000, 4'hF, q);
    check(q, e);
  endtask : rdc
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  always @(posedge to) begin
    miscompares++;
    summarize();
  end
  initial begin
    logic [31:0] r;
    logic [15:0] v5, v6;
    logic ea;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rdc(8'h14, 32'h0000);
    rdc(8'h18, 32'h0000);
    rdc(8'h1C, 32'h0100);
    rdc(8'h00, 32'h0000);
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      v6 = r[31:16] & 16'hF1FF;
      v6[8] = i[0];
      v5 = {r[15:8], i[1:0], i[3:2], (i < 2) ? {4{i[0]}} : r[3:0]};
      @(posedge clk) tune_channel_index <= r[25:16];
      wr(8'h18, v6, 4'hF);
      wr(8'h14, v5, 4'hF);
      rdc(8'h18, {16'h0000, v6});
      rdc(8'h14, {16'h0000, v5});
      rdc(8'h40, {27'h0000000, 2'h1, 1'h0, (v5[5:4] == 2'h3), (v5[7:6] == 2'h3)});
      repeat (2) @(posedge clk);
      #1;
      check(32'(bi), 32'(v5[7:6] == 2'h3));
      check(32'(step), 32'(exp_step(v5[5:4])));
      check(32'(freq), 32'(exp_step(v5[5:4])) * 32'(r[25:16]) + ((v5[7:6] == 2'h0) ? 32'h155CC : 32'h128E0));
      check(32'(sm), 32'(v5[3:0] == 4'h0));
      check(32'(att), 32'(exp_att(v5[3:0], v6[8])));
      check(32'({ext, rate}), 32'({v6[8], v6[15:14]}));
      check(32'(dep), 32'(5'h10 - {2'h0, v6[13:12], 1'b0}));
    end
    wr(8'h18, 16'hFFFF, 4'hF);
    rdc(8'h18, 32'hF1FF);
    wr(8'h14, 16'h1234, 4'hF);
    wr(8'h14, 16'hABCD, 4'h1);
    rdc(8'h14, 32'h12CD);
    wr(8'h00, 16'hFFFF, 4'hF);
    rdc(8'h00, 32'h0000);
    for (int p = 0; p < 2; p++) begin
      wr(8'h18, (p == 1) ? 16'h005C : 16'h0000, 4'hF);
      wr(8'h14, 16'h4000, 4'hF);
      repeat (3) @(posedge clk);
      for (int i = 0; i < 25; i++) begin
        r = rnd();
        @(posedge clk);
        cv <= (i < 24);
        cl <= 8'h3E + {5'h00, r[2:0]};
        cn <= 4'h3 + {2'h0, r[4:3]};
        ci <= 5'h02 + {2'h0, r[7:5]};
        #1;
        if (i > 0) check(32'(acc), 32'(ea));
        ea = (cl >= 8'h40) && (p == 0 || (cn >= 4'h5 && ci <= 5'h04));
      end
    end
    u_host.up(1'b1);
    repeat (2) @(posedge clk);
    #1;
    check(32'({xo, bl, br}), 32'h4);
    rdc(8'h1C, 32'hFC04);
    u_host.down(1'b1);
    repeat (6) @(posedge clk);
    #1;
    check(32'({xo, bl, br}), 32'h3);
    rdc(8'h1C, 32'h4100);
    rdc(8'h40, 32'h000C);
    @(posedge clk) io <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check(32'({bl, br}), 32'h0);
    summarize();
  end
endmodule : tb_top
